// *** bps_device.sv ***
/*
 * Mode and protection sequencer of the pack monitor: sleep, normal and
 * monitor modes, fault latching, FET drives and the serial control byte.
 * Assumes comparator, wake and link inputs are asynchronous to clock.
 */
// Summary of operation
// - Normal mode samples each cell in turn
// - Over-current comparator is watched every cycle
// - Any violation turns off a FET drive
// - Over-discharge sends the device to sleep
// - Regulator output is off while asleep
// - Monitor mode routes selected signal to output
// - Protection stays active in monitor mode
// - Gate drive low is on, high off
// - Host sets balance FET drives over serial
// - First connection enters and holds sleep
// - Only the wake detector ends sleep
// - Host holds link lines low at wake
// - Control byte clears on every wake from sleep; a return from monitor to normal keeps it
// - Enable bits zero keep both FETs off
// - Host sets enable bits to start pack
// - Host waits detect delay plus 200ms
// - Charge drive high on over-charge
// - Discharge drive high on over-discharge/current
`timescale 1ns/1ps
`default_nettype none
`include "bps_defs.svh"
module bps_device #(
    parameter int unsigned SAMPLE_CYCLES = `BPS_SAMPLE_US * `BPS_CLK_MHZ
)
(
    input wire logic clock,
    input wire logic reset,
    bps_link_if.device link,
    input wire logic [3:0] cell_overcharge,
    input wire logic [3:0] cell_overdischarge,
    input wire logic overcurrent,
    input wire logic wake_detect,
    output logic charge_fet_drive_output,
    output logic discharge_fet_drive_output,
    output logic [3:0] cell_balance_fet_controls,
    output logic [2:0] analog_monitor_select,
    output logic monitor_active
);
    localparam int IN_W = 16;

    // Two-stage synchroniser for every pin input
    logic [IN_W-1:0] pin_meta;
    logic [IN_W-1:0] pin_sync;
    logic s_sel;
    logic s_clk;
    logic s_din;
    logic [2:0] s_asel;
    logic [3:0] s_ov;
    logic [3:0] s_uv;
    logic s_oc;
    logic s_wake;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {link.spi_select, link.spi_clock, link.spi_data_in, link.analog_select_inputs,
                         cell_overcharge, cell_overdischarge, overcurrent, wake_detect};
            pin_sync <= pin_meta;
        end
    end

    assign {s_sel, s_clk, s_din, s_asel, s_ov, s_uv, s_oc, s_wake} = pin_sync;

    bps_pkg::bps_mode_e mode;
    bps_pkg::bps_mode_e next_mode;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [3:0] ov_flags;
    logic [3:0] next_ov_flags;
    logic oc_latch;
    logic next_oc_latch;
    logic [15:0] sample_cnt;
    logic [15:0] next_sample_cnt;
    logic [1:0] cell_idx;
    logic [1:0] next_cell_idx;
    logic chg_off;
    logic next_chg_off;
    logic dsg_off;
    logic next_dsg_off;
    logic reg_on;
    logic next_reg_on;
    logic [3:0] bal;
    logic [3:0] next_bal;
    logic [2:0] amux;
    logic [2:0] next_amux;

    // Serial port state
    logic clk_prev;
    logic next_clk_prev;
    logic sel_prev;
    logic next_sel_prev;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic dout;
    logic next_dout;

    logic awake;
    logic sample_tick;
    logic frame_done;
    logic [7:0] status_byte;

    assign awake = (mode != bps_pkg::BPS_SLEEP);
    assign sample_tick = (sample_cnt == 16'(SAMPLE_CYCLES - 1));
    assign frame_done = awake && sel_prev && !s_sel && (bit_cnt == `BPS_SPI_BITS);

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`BPS_STAT_REG_ON] = reg_on;
        status_byte[`BPS_STAT_DSG_OFF] = dsg_off;
        status_byte[`BPS_STAT_CHG_OFF] = chg_off;
        status_byte[`BPS_STAT_OV] = |ov_flags;
        status_byte[`BPS_STAT_OC] = oc_latch;
        status_byte[`BPS_STAT_MONITOR] = (mode == bps_pkg::BPS_MONITOR);
    end

    // Mode sequencing and protection
    always_comb
    begin
        next_mode = mode;
        next_ctrl = ctrl;
        next_ov_flags = ov_flags;
        next_oc_latch = oc_latch;
        next_sample_cnt = sample_cnt;
        next_cell_idx = cell_idx;
        case (mode)
            bps_pkg::BPS_SLEEP:
            begin
                // Held clear so every wake starts from zero
                next_ctrl = `BPS_CTRL_RESET;
                next_ov_flags = 4'h0;
                next_oc_latch = 1'b0;
                next_sample_cnt = 16'h0000;
                next_cell_idx = 2'h0;
                if (s_wake)
                begin
                    next_mode = bps_pkg::BPS_NORMAL;
                end
            end
            bps_pkg::BPS_NORMAL, bps_pkg::BPS_MONITOR:
            begin
                // Protection runs identically in both awake modes
                next_mode = (s_asel != 3'h0) ? bps_pkg::BPS_MONITOR : bps_pkg::BPS_NORMAL;
                if (frame_done)
                begin
                    next_ctrl = rx_shift;
                    next_ctrl[`BPS_CTRL_OC_CLEAR] = 1'b0;
                    if (rx_shift[`BPS_CTRL_OC_CLEAR])
                    begin
                        next_oc_latch = 1'b0;
                    end
                end
                // Comparator set wins over a same-cycle clear
                if (s_oc)
                begin
                    next_oc_latch = 1'b1;
                end
                next_sample_cnt = sample_tick ? 16'h0000 : 16'(sample_cnt + 16'h0001);
                if (sample_tick)
                begin
                    next_cell_idx = 2'(cell_idx + 2'h1);
                    next_ov_flags[cell_idx] = s_ov[cell_idx];
                    if (s_uv[cell_idx])
                    begin
                        next_mode = bps_pkg::BPS_SLEEP;
                    end
                end
            end
            default:
            begin
                next_mode = bps_pkg::BPS_SLEEP;
            end
        endcase
    end

    // Drives are registered; high turns the P-channel FET off
    always_comb
    begin
        next_reg_on = awake && (next_mode != bps_pkg::BPS_SLEEP);
        next_chg_off = !next_reg_on || !ctrl[`BPS_CTRL_CHG_EN] || (|ov_flags);
        next_dsg_off = !next_reg_on || !ctrl[`BPS_CTRL_DSG_EN] || oc_latch || s_oc;
        next_bal = next_reg_on ? ctrl[`BPS_CTRL_BAL_LSB +: 4] : 4'h0;
        next_amux = (mode == bps_pkg::BPS_MONITOR) ? s_asel : 3'h0;
    end

    // Serial slave: sample on rising clock, shift out on falling
    always_comb
    begin
        next_clk_prev = s_clk;
        next_sel_prev = s_sel;
        next_rx_shift = rx_shift;
        next_bit_cnt = bit_cnt;
        next_tx_shift = tx_shift;
        next_dout = dout;
        if (!awake || !s_sel)
        begin
            // Host is unpowered or idle; keep the data line low
            next_bit_cnt = (awake && sel_prev) ? bit_cnt : 4'h0;
            next_tx_shift = status_byte;
            next_dout = 1'b0;
        end
        else if (!sel_prev)
        begin
            next_bit_cnt = 4'h0;
            next_tx_shift = {status_byte[6:0], 1'b0};
            next_dout = status_byte[7];
        end
        else if (s_clk && !clk_prev)
        begin
            next_rx_shift = {rx_shift[6:0], s_din};
            if (bit_cnt != `BPS_SPI_BITS)
            begin
                next_bit_cnt = 4'(bit_cnt + 4'h1);
            end
        end
        else if (!s_clk && clk_prev)
        begin
            next_dout = tx_shift[7];
            next_tx_shift = {tx_shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mode <= bps_pkg::BPS_SLEEP;
            ctrl <= `BPS_CTRL_RESET;
            ov_flags <= 4'h0;
            oc_latch <= 1'b0;
            sample_cnt <= 16'h0000;
            cell_idx <= 2'h0;
            chg_off <= 1'b1;
            dsg_off <= 1'b1;
            reg_on <= 1'b0;
            bal <= 4'h0;
            amux <= 3'h0;
            clk_prev <= 1'b0;
            sel_prev <= 1'b0;
            rx_shift <= 8'h00;
            bit_cnt <= 4'h0;
            tx_shift <= 8'h00;
            dout <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            ctrl <= next_ctrl;
            ov_flags <= next_ov_flags;
            oc_latch <= next_oc_latch;
            sample_cnt <= next_sample_cnt;
            cell_idx <= next_cell_idx;
            chg_off <= next_chg_off;
            dsg_off <= next_dsg_off;
            reg_on <= next_reg_on;
            bal <= next_bal;
            amux <= next_amux;
            clk_prev <= next_clk_prev;
            sel_prev <= next_sel_prev;
            rx_shift <= next_rx_shift;
            bit_cnt <= next_bit_cnt;
            tx_shift <= next_tx_shift;
            dout <= next_dout;
        end
    end

    assign charge_fet_drive_output = chg_off;
    assign discharge_fet_drive_output = dsg_off;
    assign cell_balance_fet_controls = bal;
    assign analog_monitor_select = amux;
    assign monitor_active = (mode == bps_pkg::BPS_MONITOR);
    assign link.regulator_output = reg_on;
    assign link.spi_data_out = dout;
endmodule
`default_nettype wire

// *** bps_defs.svh ***
/*
 * Shared constants of the pack protection sequencer: control byte layout,
 * status byte layout, timing counts and host register offsets.
 * Assumes a 200 MHz system clock on both ends.
 */
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

`define BPS_CLK_MHZ 200
`define BPS_SAMPLE_US 100
`define BPS_CELLS 4
`define BPS_SPI_BITS 4'h8
`define BPS_SPI_HALF_CYCLES 8'h08

`define BPS_CTRL_RESET 8'h00
`define BPS_CTRL_DSG_EN 0
`define BPS_CTRL_CHG_EN 1
`define BPS_CTRL_BAL_LSB 2
`define BPS_CTRL_OC_CLEAR 6

`define BPS_STAT_REG_ON 0
`define BPS_STAT_DSG_OFF 1
`define BPS_STAT_CHG_OFF 2
`define BPS_STAT_OV 3
`define BPS_STAT_OC 4
`define BPS_STAT_MONITOR 5

`define BPS_ADDR_TX 8'h00
`define BPS_ADDR_STATUS 8'h04
`define BPS_ADDR_ASEL 8'h08
`define BPS_STATUS_BUSY 8
`define BPS_STATUS_LINK_UP 9

`endif

// *** bps_pkg.sv ***
/*
 * Types of the pack protection sequencer.
 * Assumes nothing beyond the shared constants header.
 */
`default_nettype none
package bps_pkg;
    typedef enum logic [1:0] {
        BPS_SLEEP = 2'b00,
        BPS_NORMAL = 2'b01,
        BPS_MONITOR = 2'b10
    } bps_mode_e;

    typedef enum logic [1:0] {
        BPS_H_IDLE = 2'b00,
        BPS_H_SHIFT = 2'b01,
        BPS_H_RELEASE = 2'b10
    } bps_host_e;
endpackage
`default_nettype wire

// *** bps_link_if.sv ***
/*
 * Link between the protection device and its microcontroller: serial port,
 * analog select lines and the regulator output that powers the host.
 * Assumes both ends run on their own copy of the 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bps_link_if;
    logic spi_select;
    logic spi_clock;
    logic spi_data_in;
    logic spi_data_out;
    logic [2:0] analog_select_inputs;
    logic regulator_output;

    modport device
    (
        input spi_select,
        input spi_clock,
        input spi_data_in,
        input analog_select_inputs,
        output spi_data_out,
        output regulator_output
    );

    modport host
    (
        output spi_select,
        output spi_clock,
        output spi_data_in,
        output analog_select_inputs,
        input spi_data_out,
        input regulator_output
    );
endinterface
`default_nettype wire

// *** bps_host.sv ***
/*
 * Microcontroller end of the pack link: an APB slave whose registers send a
 * control byte over the serial port, return the status byte and drive the
 * analog select lines. Assumes APB on the same 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bps_defs.svh"
module bps_host
(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    bps_link_if.host link
);
    logic [1:0] in_meta;
    logic [1:0] in_sync;
    logic s_dout;
    logic s_power;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            in_meta <= 2'b00;
            in_sync <= 2'b00;
        end
        else
        begin
            in_meta <= {link.spi_data_out, link.regulator_output};
            in_sync <= in_meta;
        end
    end

    assign {s_dout, s_power} = in_sync;

    bps_pkg::bps_host_e st;
    bps_pkg::bps_host_e next_st;
    logic [7:0] div;
    logic [7:0] next_div;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic [3:0] bits;
    logic [3:0] next_bits;
    logic sel;
    logic next_sel;
    logic sclk;
    logic next_sclk;
    logic din;
    logic next_din;
    logic [2:0] asel;
    logic [2:0] next_asel;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic acc;
    logic wr;
    logic half;
    logic mapped;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign half = (div == `BPS_SPI_HALF_CYCLES - 8'h01);
    assign mapped = (paddr == `BPS_ADDR_TX) || (paddr == `BPS_ADDR_STATUS) || (paddr == `BPS_ADDR_ASEL);

    always_comb
    begin
        next_st = st;
        next_div = (st == bps_pkg::BPS_H_IDLE || half) ? 8'h00 : 8'(div + 8'h01);
        next_tx = tx;
        next_rx = rx;
        next_bits = bits;
        next_sel = sel;
        next_sclk = sclk;
        next_din = din;
        next_asel = asel;
        next_rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `BPS_ADDR_STATUS: next_rdata = {22'h0, s_power, (st != bps_pkg::BPS_H_IDLE), rx};
                `BPS_ADDR_ASEL: next_rdata = {29'h0, asel};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (wr && paddr == `BPS_ADDR_ASEL)
        begin
            next_asel = pwdata[2:0];
        end
        case (st)
            bps_pkg::BPS_H_IDLE:
            begin
                // Writes while busy or unpowered are dropped
                if (wr && paddr == `BPS_ADDR_TX && s_power)
                begin
                    next_st = bps_pkg::BPS_H_SHIFT;
                    next_tx = {pwdata[6:0], 1'b0};
                    next_din = pwdata[7];
                    next_sel = 1'b1;
                    next_bits = 4'h0;
                end
            end
            bps_pkg::BPS_H_SHIFT:
            begin
                if (half)
                begin
                    next_sclk = !sclk;
                    if (!sclk)
                    begin
                        next_rx = {rx[6:0], s_dout};
                        next_bits = 4'(bits + 4'h1);
                    end
                    else if (bits == `BPS_SPI_BITS)
                    begin
                        next_st = bps_pkg::BPS_H_RELEASE;
                        next_din = 1'b0;
                    end
                    else
                    begin
                        next_din = tx[7];
                        next_tx = {tx[6:0], 1'b0};
                    end
                end
            end
            bps_pkg::BPS_H_RELEASE:
            begin
                if (half)
                begin
                    next_sel = 1'b0;
                    next_st = bps_pkg::BPS_H_IDLE;
                end
            end
            default:
            begin
                next_st = bps_pkg::BPS_H_IDLE;
            end
        endcase
        // Unpowered host lets every line fall low
        if (!s_power)
        begin
            next_st = bps_pkg::BPS_H_IDLE;
            next_sel = 1'b0;
            next_sclk = 1'b0;
            next_din = 1'b0;
            next_asel = 3'h0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st <= bps_pkg::BPS_H_IDLE;
            div <= 8'h00;
            tx <= 8'h00;
            rx <= 8'h00;
            bits <= 4'h0;
            sel <= 1'b0;
            sclk <= 1'b0;
            din <= 1'b0;
            asel <= 3'h0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            st <= next_st;
            div <= next_div;
            tx <= next_tx;
            rx <= next_rx;
            bits <= next_bits;
            sel <= next_sel;
            sclk <= next_sclk;
            din <= next_din;
            asel <= next_asel;
            rdata <= next_rdata;
        end
    end

    assign prdata = rdata;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign link.spi_select = sel;
    assign link.spi_clock = sclk;
    assign link.spi_data_in = din;
    assign link.analog_select_inputs = asel;
endmodule
`default_nettype wire

// *** bps_chk.sv ***
/*
 * Concurrent checks on the link between the two ends and on the device drives.
 * Assumes one 200 MHz clock, synchronous active-high reset, link signals as plain inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module bps_chk #(
    parameter int unsigned SAMPLE_CYCLES = 8
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic spi_select,
    input wire logic spi_clock,
    input wire logic [2:0] analog_select_inputs,
    input wire logic regulator_output,
    input wire logic [3:0] cell_overdischarge,
    input wire logic overcurrent,
    input wire logic wake_detect,
    input wire logic charge_fet_drive_output,
    input wire logic discharge_fet_drive_output,
    input wire logic [2:0] analog_monitor_select,
    input wire logic monitor_active
);
    logic clk_q;
    logic next_clk_q;
    logic [3:0] rises;
    logic [3:0] next_rises;
    logic [15:0] od_wait;
    logic [15:0] next_od_wait;

    always_comb
    begin
        next_clk_q = spi_clock;
        next_rises = spi_select ? rises + {3'h0, spi_clock & ~clk_q} : 4'h0;
        next_od_wait = (regulator_output && |cell_overdischarge) ? od_wait + 16'h1 : 16'h0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            clk_q <= 1'h0;
            rises <= 4'h0;
            od_wait <= 16'h0;
        end
        else
        begin
            clk_q <= next_clk_q;
            rises <= next_rises;
            od_wait <= next_od_wait;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence seq_sel_steady;
        (regulator_output && analog_select_inputs != 3'h0 && $stable(analog_select_inputs)) [*6];
    endsequence
    sequence seq_sel_idle;
        (regulator_output && analog_select_inputs == 3'h0) [*6];
    endsequence

    property p_asleep_off;
        !regulator_output [*2] |-> charge_fet_drive_output && discharge_fet_drive_output;
    endproperty
    property p_wake_only;
        $rose(regulator_output) |-> $past(wake_detect, 3);
    endproperty
    property p_entry_cleared;
        $rose(regulator_output) |-> charge_fet_drive_output && discharge_fet_drive_output;
    endproperty
    property p_oc_trip;
        $rose(overcurrent) && regulator_output |-> ##[1:5] discharge_fet_drive_output;
    endproperty
    property p_od_sleep;
        od_wait <= 16'(4 * SAMPLE_CYCLES + 12);
    endproperty
    property p_monitor_route;
        seq_sel_steady |-> monitor_active && analog_monitor_select == analog_select_inputs;
    endproperty
    property p_normal_route;
        seq_sel_idle |-> !monitor_active && analog_monitor_select == 3'h0;
    endproperty
    property p_clk_idle;
        !spi_select |-> !spi_clock;
    endproperty
    property p_half_period;
        $rose(spi_clock) |-> spi_clock [*4];
    endproperty
    property p_frame_len;
        $fell(spi_select) |-> rises == 4'h8;
    endproperty

    a_asleep_off: assert property (p_asleep_off) else $error("FET drive on while regulator off");
    a_wake_only: assert property (p_wake_only) else $error("Regulator rose without wake level");
    a_entry_cleared: assert property (p_entry_cleared) else $error("FET drive on at normal entry");
    a_oc_trip: assert property (p_oc_trip) else $error("Over-current did not cut discharge");
    a_od_sleep: assert property (p_od_sleep) else $error("Over-discharge did not end in sleep");
    a_monitor_route: assert property (p_monitor_route) else $error("Monitor route wrong");
    a_normal_route: assert property (p_normal_route) else $error("Monitor route active in normal");
    a_clk_idle: assert property (p_clk_idle) else $error("Serial clock high outside frame");
    a_half_period: assert property (p_half_period) else $error("Serial clock high too short");
    a_frame_len: assert property (p_frame_len) else $error("Frame without eight clock pulses");
endmodule
`default_nettype wire

// *** tb_battery_protect_mode_sequencer.sv ***
/*
 * Self-checking bench: both ends joined by the link, host driven over APB.
 * Assumes the shared constants header and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bps_defs.svh"
module tb_battery_protect_mode_sequencer;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, rerr;
    logic overcurrent, wake_detect, charge_fet_drive_output, discharge_fet_drive_output, monitor_active;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] cell_overcharge, cell_overdischarge, cell_balance_fet_controls, bal;
    logic [2:0] analog_monitor_select, asel;
    int errors, n_compared;

    bps_link_if link_bus();
    bps_device #(.SAMPLE_CYCLES(8)) u_bps_device (.clock(clock), .reset(reset), .link(link_bus.device),
        .cell_overcharge(cell_overcharge), .cell_overdischarge(cell_overdischarge), .overcurrent(overcurrent),
        .wake_detect(wake_detect), .charge_fet_drive_output(charge_fet_drive_output),
        .discharge_fet_drive_output(discharge_fet_drive_output),
        .cell_balance_fet_controls(cell_balance_fet_controls), .analog_monitor_select(analog_monitor_select),
        .monitor_active(monitor_active));
    bps_host u_bps_host (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(link_bus.host));
    bps_chk #(.SAMPLE_CYCLES(8)) u_bps_chk (.clock(clock), .reset(reset), .spi_select(link_bus.spi_select),
        .spi_clock(link_bus.spi_clock), .analog_select_inputs(link_bus.analog_select_inputs),
        .regulator_output(link_bus.regulator_output), .cell_overdischarge(cell_overdischarge),
        .overcurrent(overcurrent), .wake_detect(wake_detect), .charge_fet_drive_output(charge_fet_drive_output),
        .discharge_fet_drive_output(discharge_fet_drive_output), .analog_monitor_select(analog_monitor_select),
        .monitor_active(monitor_active));

    task automatic print_verdict();
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] ctrl(input logic [3:0] b, input logic chg, input logic dsg, input logic clr);
        return {1'h0, clr, b, chg, dsg};
    endfunction

    function automatic logic [7:0] stat(input logic mon, input logic oc, input logic chg_off, input logic dsg_off);
        return {2'h0, mon, oc, 1'h0, chg_off, dsg_off, 1'h1};
    endfunction

    // Starts one edge late so a strobe is never reassigned within one step
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1)
        begin
            @(posedge clock);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic poll(input int idx, input logic want);
        int n;
        n = 0;
        do
        begin
            apb(1'h0, `BPS_ADDR_STATUS, 32'h0);
            n++;
        end
        while (rdata[idx] !== want && n < 100);
        check("status poll", rdata[idx], want);
    endtask

    // Leaves the status byte of the frame in rdata
    task automatic send(input logic [7:0] b);
        poll(`BPS_STATUS_BUSY, 1'h0);
        apb(1'h1, `BPS_ADDR_TX, {24'h0, b});
        repeat (2) @(posedge clock);
        poll(`BPS_STATUS_BUSY, 1'h0);
        repeat (8) @(posedge clock);
    endtask

    task automatic drives(input logic [1:0] exp);
        check("fet drives", {charge_fet_drive_output, discharge_fet_drive_output}, exp);
    endtask

    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    initial
    begin
        repeat (30000) @(posedge clock);
        errors++;
        print_verdict();
    end

    initial
    begin
        {reset, psel, penable, pwrite, overcurrent, wake_detect} = 6'h20;
        {paddr, pwdata, cell_overcharge, cell_overdischarge} = 48'h0;
        void'($urandom(32'h4273));
        repeat (8) @(posedge clock);
        reset <= 1'h0;
        repeat (40) @(posedge clock);
        check("regulator", link_bus.regulator_output, 1'h0);
        drives(2'h3);
        wake_detect <= 1'h1;
        poll(`BPS_STATUS_LINK_UP, 1'h1);
        drives(2'h3);
        // One full sampling round plus margin before the FETs go on
        repeat (48) @(posedge clock);
        send(ctrl(4'h0, 1'h1, 1'h1, 1'h0));
        check("status", rdata[7:0], stat(1'h0, 1'h0, 1'h1, 1'h1));
        drives(2'h0);
        for (int i = 0; i < 6; i++)
        begin
            bal = (i == 0) ? 4'hF : 4'($urandom);
            send(ctrl(bal, 1'h1, 1'h1, 1'h0));
            check("balance", cell_balance_fet_controls, bal);
            check("status", rdata[7:0], stat(1'h0, 1'h0, 1'h0, 1'h0));
        end
        for (int e = 0; e < 4; e++)
        begin
            send(ctrl(4'h0, e[1], e[0], 1'h0));
            drives({~e[1], ~e[0]});
        end
        cell_overcharge <= 4'($urandom_range(15, 1));
        repeat (60) @(posedge clock);
        drives(2'h2);
        cell_overcharge <= 4'h0;
        repeat (60) @(posedge clock);
        drives(2'h0);
        overcurrent <= 1'h1;
        repeat (10) @(posedge clock);
        drives(2'h1);
        overcurrent <= 1'h0;
        repeat (20) @(posedge clock);
        drives(2'h1);
        send(ctrl(4'h0, 1'h1, 1'h1, 1'h1));
        check("status", rdata[7:0], stat(1'h0, 1'h1, 1'h0, 1'h1));
        drives(2'h0);
        asel = 3'($urandom_range(7, 1));
        apb(1'h1, `BPS_ADDR_ASEL, {29'h0, asel});
        repeat (10) @(posedge clock);
        check("monitor", {monitor_active, analog_monitor_select}, {1'h1, asel});
        overcurrent <= 1'h1;
        repeat (10) @(posedge clock);
        drives(2'h1);
        overcurrent <= 1'h0;
        // Balance left on so the wake below must clear it
        send(ctrl(4'h9, 1'h1, 1'h1, 1'h1));
        check("status", rdata[7:0], stat(1'h1, 1'h1, 1'h0, 1'h1));
        check("balance", cell_balance_fet_controls, 4'h9);
        apb(1'h0, `BPS_ADDR_ASEL, 32'h0);
        check("select readback", rdata[2:0], asel);
        apb(1'h1, `BPS_ADDR_ASEL, 32'h0);
        repeat (10) @(posedge clock);
        check("monitor", {monitor_active, analog_monitor_select}, 4'h0);
        apb(1'h0, 8'h0C, 32'h0);
        check("unmapped error", rerr, 1'h1);
        check("unmapped data", rdata, 32'h0000_0000);
        wake_detect <= 1'h0;
        cell_overdischarge <= 4'h8;
        repeat (60) @(posedge clock);
        check("regulator", link_bus.regulator_output, 1'h0);
        drives(2'h3);
        cell_overdischarge <= 4'h0;
        repeat (100) @(posedge clock);
        check("regulator", link_bus.regulator_output, 1'h0);
        wake_detect <= 1'h1;
        poll(`BPS_STATUS_LINK_UP, 1'h1);
        check("balance", cell_balance_fet_controls, 4'h0);
        drives(2'h3);
        send(ctrl(4'h0, 1'h0, 1'h0, 1'h0));
        check("status", rdata[7:0], stat(1'h0, 1'h0, 1'h1, 1'h1));
        check("balance", cell_balance_fet_controls, 4'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
